/* File: rtl/ssadc_pkg.sv */
package ssadc_pkg;

  // register offsets (byte addresses on the plain register port)
  localparam logic [3:0] SEQ_CFG_OFS  = 4'h0;
  localparam logic [3:0] MODE_CFG_OFS = 4'h1;
  localparam logic [3:0] TIMER_PRESCALER_LO_OFS  = 4'h2;
  localparam logic [3:0] START_OFS    = 4'h3;
  localparam logic [3:0] STATUS_OFS   = 4'h4;
  localparam logic [3:0] MASK_OFS     = 4'h5;
  localparam logic [3:0] CHANNEL_SELECT_OFS     = 4'h6;

  // reset values
  localparam logic [7:0] CFG_RST = 8'h00;

  // field positions, sequence config
  localparam int REF_CONTINUOUS_SELECT_BIT = 0;
  localparam int CONT_BIT     = 1;
  localparam int MULTI_BIT    = 2;
  localparam int CHANNEL_SELECT_LSB     = 3;
  localparam int REP_LSB      = 6;
  // field positions, mode config
  localparam int MODE_BIT     = 0;
  localparam int REFSEL_BIT   = 1;
  localparam int POL_BIT      = 2;
  localparam int DIR_BIT      = 3;
  localparam int INTSEQ_BIT   = 4;
  localparam int CUR_LSB      = 5;
  // field positions, start register
  localparam int START_BIT    = 0;
  localparam int RAMP_BIT     = 1;
  localparam int PRESHI_LSB   = 4;
  // status bits
  localparam int EV_CHANNEL_SELECT_BIT  = 0;
  localparam int EV_SEQ_BIT   = 1;

  localparam logic [2:0] LAST_CHANNEL_SELECT = 3'h5;
  localparam logic [1:0] REP_UNUSED = 2'h3;
  localparam logic [2:0] REF_SLOT   = 3'h7; // mux code of internal reference

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_CONTINUOUS_SELECT = 2'b01,
    SS_WAIT = 2'b10
  } ssadc_state_e;

  // analog side configuration handed to the front end
  typedef struct packed {
    logic       compare;   // 0 comparator, 1 a/d
    logic       refSelect;
    logic       crossingPolarity;
    logic       countDirection;
    logic       rampSourceSelect;
    logic [2:0] chargeCurrentSelect;
    logic [11:0] timerPrescaler;
  } ssadc_front_s;

  typedef struct packed {
    ssadc_state_e state;
    logic [7:0]   seqCfg;
    logic [7:0]   modeCfg;
    logic [7:0]   presLo;
    logic [7:0]   startCfg;
    logic [1:0]   status;
    logic [1:0]   mask;
    logic [2:0]   channel_select;       // current data channel
    logic         refPhase;   // converting the reference after data
    logic [1:0]   rep;        // repeats done on current channel
    logic         convStart;  // one-cycle start pulse to front end
    logic         startSeen;  // start consumed by a single pass
    logic [7:0]   rdata;
  } ssadc_state_s;

endpackage : ssadc_pkg

/* File: rtl/ssadc_seq.sv */
`timescale 1ns/1ps

module ssadc_seq (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [3:0]            regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [7:0]            regRdata,
  input  wire logic                  convDone,
  output logic                       convStart,
  output logic      [2:0]            muxSelect,
  output ssadc_pkg::ssadc_front_s    frontCfg,
  output logic                       busy,
  output logic                       irq
);

  ssadc_pkg::ssadc_state_s cur_ff;
  ssadc_pkg::ssadc_state_s nxt_cur;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // last repeat index per channel (conversions minus one), unused code treated as one conversion
  function automatic logic [1:0] ssadc_last_rep(input logic [1:0] f);
    ssadc_last_rep = (f == ssadc_pkg::REP_UNUSED) ? 2'h0 : f;
  endfunction : ssadc_last_rep

  // clamps unused channel codes to the highest real channel
  function automatic logic [2:0] ssadc_clamp_channel_select(input logic [2:0] c);
    ssadc_clamp_channel_select = (c > ssadc_pkg::LAST_CHANNEL_SELECT) ? ssadc_pkg::LAST_CHANNEL_SELECT : c;
  endfunction : ssadc_clamp_channel_select

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic       adMode;
  logic       startBit;
  logic       multi;
  logic       cont;
  logic       refEn;
  logic       intSeq;
  logic [2:0] lastChan;
  logic [1:0] lastRep;
  logic [1:0] events;
  logic       chanDone;
  logic       passDone;

  always_comb
  begin
    nxt_cur   = cur_ff;
    adMode    = cur_ff.modeCfg[ssadc_pkg::MODE_BIT];
    startBit  = cur_ff.startCfg[ssadc_pkg::START_BIT];
    multi     = cur_ff.seqCfg[ssadc_pkg::MULTI_BIT];
    cont      = cur_ff.seqCfg[ssadc_pkg::CONT_BIT];
    refEn     = cur_ff.seqCfg[ssadc_pkg::REF_CONTINUOUS_SELECT_BIT];
    intSeq    = cur_ff.modeCfg[ssadc_pkg::INTSEQ_BIT];
    lastChan  = ssadc_clamp_channel_select(cur_ff.seqCfg[ssadc_pkg::CHANNEL_SELECT_LSB +: 3]);
    lastRep   = ssadc_last_rep(cur_ff.seqCfg[ssadc_pkg::REP_LSB +: 2]);
    events    = 2'h0;
    chanDone  = 1'b0;
    passDone  = 1'b0;
    nxt_cur.convStart = 1'b0;
    nxt_cur.rdata     = 8'h00;

    // register writes
    if (regWr)
    begin
      unique case (regAddr)
        ssadc_pkg::SEQ_CFG_OFS:  nxt_cur.seqCfg   = regWdata;
        ssadc_pkg::MODE_CFG_OFS: nxt_cur.modeCfg  = regWdata;
        ssadc_pkg::TIMER_PRESCALER_LO_OFS:  nxt_cur.presLo   = regWdata;
        ssadc_pkg::START_OFS:    nxt_cur.startCfg = regWdata;
        ssadc_pkg::MASK_OFS:     nxt_cur.mask     = regWdata[1:0];
        default: ;
      endcase
    end

    // sequencer
    unique case (cur_ff.state)
      ssadc_pkg::SS_IDLE:
      begin
        if (startBit && adMode && !cur_ff.startSeen)
        begin
          nxt_cur.channel_select      = multi ? 3'h0 : lastChan;
          nxt_cur.refPhase  = 1'b0;
          nxt_cur.rep       = 2'h0;
          nxt_cur.convStart = 1'b1;
          nxt_cur.state     = ssadc_pkg::SS_CONTINUOUS_SELECT;
        end
      end
      ssadc_pkg::SS_CONTINUOUS_SELECT:
      begin
        if (convDone)
        begin
          nxt_cur.convStart = 1'b1;
          if (refEn && !cur_ff.refPhase)
            nxt_cur.refPhase = 1'b1;
          else
          begin
            nxt_cur.refPhase = 1'b0;
            if (cur_ff.rep != lastRep)
              nxt_cur.rep = cur_ff.rep + 2'h1;
            else
            begin
              chanDone    = 1'b1;
              nxt_cur.rep = 2'h0;
              if (multi && cur_ff.channel_select < lastChan)
                nxt_cur.channel_select = cur_ff.channel_select + 3'h1;
              else
              begin
                passDone     = 1'b1;
                nxt_cur.channel_select = multi ? 3'h0 : lastChan;
                if (!cont)
                begin
                  nxt_cur.convStart = 1'b0;
                  nxt_cur.startSeen = 1'b1;
                  nxt_cur.state     = ssadc_pkg::SS_IDLE;
                end
              end
            end
          end
        end
      end
      default: nxt_cur.state = ssadc_pkg::SS_IDLE;
    endcase

    // clearing start stops at once and rearms a single pass
    if (!nxt_cur.startCfg[ssadc_pkg::START_BIT] ||
        !nxt_cur.modeCfg[ssadc_pkg::MODE_BIT])
    begin
      nxt_cur.state     = ssadc_pkg::SS_IDLE;
      nxt_cur.convStart = 1'b0;
      nxt_cur.startSeen = 1'b0;
    end

    events[ssadc_pkg::EV_CHANNEL_SELECT_BIT] = chanDone && !intSeq;
    events[ssadc_pkg::EV_SEQ_BIT]  = passDone && intSeq;
    // write-one-to-clear, a new event wins over the clear
    if (regWr && regAddr == ssadc_pkg::STATUS_OFS)
      nxt_cur.status = cur_ff.status & ~regWdata[1:0];
    nxt_cur.status = nxt_cur.status | events;

    // register reads, data in the next cycle
    if (regRd)
    begin
      unique case (regAddr)
        ssadc_pkg::SEQ_CFG_OFS:  nxt_cur.rdata = cur_ff.seqCfg;
        ssadc_pkg::MODE_CFG_OFS: nxt_cur.rdata = cur_ff.modeCfg;
        ssadc_pkg::TIMER_PRESCALER_LO_OFS:  nxt_cur.rdata = cur_ff.presLo;
        ssadc_pkg::START_OFS:    nxt_cur.rdata = cur_ff.startCfg;
        ssadc_pkg::STATUS_OFS:   nxt_cur.rdata = {6'h00, cur_ff.status};
        ssadc_pkg::MASK_OFS:     nxt_cur.rdata = {6'h00, cur_ff.mask};
        ssadc_pkg::CHANNEL_SELECT_OFS:     nxt_cur.rdata = {3'h0, cur_ff.refPhase,
                                   cur_ff.state != ssadc_pkg::SS_IDLE,
                                   cur_ff.channel_select};
        default:                 nxt_cur.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cur_ff          <= '0;
      cur_ff.seqCfg   <= ssadc_pkg::CFG_RST;
      cur_ff.modeCfg  <= ssadc_pkg::CFG_RST;
      cur_ff.presLo   <= ssadc_pkg::CFG_RST;
      cur_ff.startCfg <= ssadc_pkg::CFG_RST;
      cur_ff.state    <= ssadc_pkg::SS_IDLE;
    end
    else
      cur_ff <= nxt_cur;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdata  = cur_ff.rdata;
  assign convStart = cur_ff.convStart;
  assign busy      = cur_ff.state != ssadc_pkg::SS_IDLE;
  // reference slot carries the reference code so the mux sees it directly
  assign muxSelect = cur_ff.refPhase ? ssadc_pkg::REF_SLOT : cur_ff.channel_select;
  assign irq       = |(cur_ff.status & cur_ff.mask);

  // front-end configuration straight from the registers
  always_comb
  begin
    frontCfg.compare          = cur_ff.modeCfg[ssadc_pkg::MODE_BIT];
    frontCfg.refSelect        = cur_ff.modeCfg[ssadc_pkg::REFSEL_BIT];
    frontCfg.crossingPolarity = cur_ff.modeCfg[ssadc_pkg::POL_BIT];
    frontCfg.countDirection   = cur_ff.modeCfg[ssadc_pkg::DIR_BIT];
    frontCfg.rampSourceSelect = cur_ff.startCfg[ssadc_pkg::RAMP_BIT];
    frontCfg.chargeCurrentSelect = cur_ff.modeCfg[ssadc_pkg::CUR_LSB +: 3];
    frontCfg.timerPrescaler   = {cur_ff.startCfg[ssadc_pkg::PRESHI_LSB +: 4],
                                 cur_ff.presLo};
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  ref_follows_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.state == ssadc_pkg::SS_CONTINUOUS_SELECT && convDone && !cur_ff.refPhase
     && refEn && startBit && adMode && !(regWr))
    |=> (muxSelect == ssadc_pkg::REF_SLOT))
    else $error("reference not converted after data");

  data_after_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.state == ssadc_pkg::SS_CONTINUOUS_SELECT && convDone && cur_ff.refPhase
     && startBit && adMode && !regWr) |=> !cur_ff.refPhase)
    else $error("reference phase did not end");

  no_ref_a: assert property (@(posedge mclk) disable iff (rst)
    (!refEn && !$past(refEn)) |-> !cur_ff.refPhase)
    else $error("reference phase without enable");

  rep_step_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.state == ssadc_pkg::SS_CONTINUOUS_SELECT && convDone && !regWr
     && (!refEn || cur_ff.refPhase) && cur_ff.rep != lastRep)
    |=> cur_ff.rep == $past(cur_ff.rep) + 2'h1)
    else $error("repeat count did not advance");

  seq_zero_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.state == ssadc_pkg::SS_IDLE && startBit && adMode
     && !cur_ff.startSeen && multi) |=> muxSelect == 3'h0)
    else $error("sequence did not start at channel zero");

  channel_select_step_a: assert property (@(posedge mclk) disable iff (rst)
    (chanDone && multi && cur_ff.channel_select < lastChan && !regWr)
    |=> cur_ff.channel_select == $past(cur_ff.channel_select) + 3'h1)
    else $error("sequence did not step to next channel");

  single_channel_select_a: assert property (@(posedge mclk) disable iff (rst)
    (cur_ff.state == ssadc_pkg::SS_IDLE && startBit && adMode
     && !cur_ff.startSeen && !multi) |=> muxSelect == $past(lastChan))
    else $error("single channel not selected");

  channel_select_range_a: assert property (@(posedge mclk) disable iff (rst)
    busy |-> cur_ff.channel_select <= ssadc_pkg::LAST_CHANNEL_SELECT)
    else $error("channel beyond last");

  stop_a: assert property (@(posedge mclk) disable iff (rst)
    (regWr && regAddr == ssadc_pkg::START_OFS && !regWdata[0])
    |=> !busy && !convStart)
    else $error("start clear did not stop");

  start_a: assert property (@(posedge mclk) disable iff (rst)
    (!busy && regWr && regAddr == ssadc_pkg::START_OFS && regWdata[0]
     && adMode && !cur_ff.startSeen) |=> ##1 (busy && convStart))
    else $error("start did not launch");

  comp_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !adMode && !$past(adMode) |-> !busy)
    else $error("busy in comparator mode");

  mode_stop_a: assert property (@(posedge mclk) disable iff (rst)
    (regWr && regAddr == ssadc_pkg::MODE_CFG_OFS
     && !regWdata[ssadc_pkg::MODE_BIT]) |=> !busy && !convStart)
    else $error("mode clear did not stop");

  int_channel_select_a: assert property (@(posedge mclk) disable iff (rst)
    (chanDone && !intSeq) |=> cur_ff.status[ssadc_pkg::EV_CHANNEL_SELECT_BIT])
    else $error("channel interrupt missing");

  int_seq_a: assert property (@(posedge mclk) disable iff (rst)
    (chanDone && intSeq && !passDone && !(regWr && regAddr ==
     ssadc_pkg::STATUS_OFS)) |=> $stable(cur_ff.status))
    else $error("sequence interrupt too early");

  int_pass_a: assert property (@(posedge mclk) disable iff (rst)
    (passDone && intSeq) |=> cur_ff.status[ssadc_pkg::EV_SEQ_BIT])
    else $error("sequence interrupt missing");

  once_a: assert property (@(posedge mclk) disable iff (rst)
    (passDone && !cont && !regWr) |=> !busy [*2])
    else $error("single pass did not end");

  cont_run_a: assert property (@(posedge mclk) disable iff (rst)
    (passDone && cont && !regWr) |=> busy && convStart)
    else $error("continuous pass did not restart");

  timer_prescaler_a: assert property (@(posedge mclk) disable iff (rst)
    (regWr && regAddr == ssadc_pkg::TIMER_PRESCALER_LO_OFS)
    |=> frontCfg.timerPrescaler[7:0] == $past(regWdata))
    else $error("prescaler low byte lost");

  // read data stand only in the cycle after a strobe
  rdata_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !regRd |=> regRdata == 8'h00)
    else $error("read data without a read strobe");

  seq_cov_c:  cover property (@(posedge mclk) passDone && multi);
  ref_cov_c:  cover property (@(posedge mclk) cur_ff.refPhase && convDone);
  cont_cov_c: cover property (@(posedge mclk) passDone && cont);
  rep_cov_c:  cover property (@(posedge mclk) chanDone && lastRep == 2'h2);
  once_cov_c: cover property (@(posedge mclk) passDone && !multi && !cont);

endmodule : ssadc_seq

/* File: verif/ssadc_seq_tb_top.sv */
`timescale 1ns/1ps

module ssadc_seq_tb_top;
  logic                    mclk;
  logic                    rst;
  logic [3:0]              regAddr;
  logic [7:0]              regWdata;
  logic                    regWr;
  logic                    regRd;
  logic [7:0]              regRdata;
  logic                    convDone;
  logic                    convStart;
  logic [2:0]              muxSelect;
  ssadc_pkg::ssadc_front_s frontCfg;
  logic                    busy;
  logic                    irq;
  int                      err_total;
  int                      tests_run;

  ////////////////////////////////////////////////////////////////////////////
  // clock, reset and the device
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  ssadc_seq u_dut (
    .mclk      (mclk),
    .rst       (rst),
    .regAddr   (regAddr),
    .regWdata  (regWdata),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdata  (regRdata),
    .convDone  (convDone),
    .convStart (convStart),
    .muxSelect (muxSelect),
    .frontCfg  (frontCfg),
    .busy      (busy),
    .irq       (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe, released on the next edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    chk({12'h000, regRdata}, {12'h000, exp});
  endtask : rd

  // waits for a bounded start pulse, checks the slot, then answers;
  // the pulse already stands when called right after the previous answer,
  // so look before waiting for the next edge
  task automatic slot(input logic [2:0] expMux);
    int n;
    n = 0;
    #1;
    while (convStart !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({19'h0_0000, convStart}, 20'h0_0001);
    chk({17'h0_0000, muxSelect}, {17'h0_0000, expMux});
    repeat (3) @(posedge mclk);
    convDone <= 1'b1;
    @(posedge mclk);
    convDone <= 1'b0;
  endtask : slot

  // register fields must reach the front end unchanged
  task automatic front(input logic [7:0] m, input logic [7:0] s,
                       input logic [7:0] p);
    wr(ssadc_pkg::MODE_CFG_OFS, m);
    wr(ssadc_pkg::START_OFS, s);
    wr(ssadc_pkg::TIMER_PRESCALER_LO_OFS, p);
    @(posedge mclk);
    #1;
    chk(frontCfg, {m[0], m[1], m[2], m[3], s[1], m[7:5], s[7:4], p});
  endtask : front

  task automatic idle_chk(input int cyc, input logic expBusy);
    repeat (cyc) @(posedge mclk);
    #1;
    chk({19'h0_0000, busy}, {19'h0_0000, expBusy});
  endtask : idle_chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // cut a hang short well beyond the expected run
  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial
  begin
    err_total = 0;
    tests_run = 0;
    rst       = 1'b1;
    regAddr   = 4'h0;
    regWdata  = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
    convDone  = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    // reset values, then an unmapped place
    for (int a = 0; a < 4; a++)
      rd(4'(a), 8'h00);
    rd(4'hf, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    $display("test reset done");
    front(8'hef, 8'ha2, 8'h5c);
    front(8'h10, 8'h50, 8'ha3);
    // written values must read back
    rd(ssadc_pkg::MODE_CFG_OFS, 8'h10);
    rd(ssadc_pkg::START_OFS, 8'h50);
    rd(ssadc_pkg::TIMER_PRESCALER_LO_OFS, 8'ha3);
    // comparator mode must not convert even with start set
    wr(ssadc_pkg::START_OFS, 8'h01);
    idle_chk(4, 1'b0);
    wr(ssadc_pkg::START_OFS, 8'h00);
    $display("test front done");
    // channel 4, three conversions each followed by the reference
    wr(ssadc_pkg::SEQ_CFG_OFS, 8'ha1);
    wr(ssadc_pkg::MODE_CFG_OFS, 8'h03);
    wr(ssadc_pkg::MASK_OFS, 8'h01);
    wr(ssadc_pkg::START_OFS, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      slot(3'h4);
      slot(3'h7);
    end
    idle_chk(4, 1'b0);
    chk({19'h0_0000, irq}, 20'h0_0001);
    rd(ssadc_pkg::STATUS_OFS, 8'h01);
    // a single pass must not rerun while start stays set
    idle_chk(20, 1'b0);
    wr(ssadc_pkg::STATUS_OFS, 8'h03);
    idle_chk(1, 1'b0);
    chk({19'h0_0000, irq}, 20'h0_0000);
    $display("test single done");
    // sequence 0..2, interrupt only at the end of the sequence
    wr(ssadc_pkg::START_OFS, 8'h00);
    wr(ssadc_pkg::SEQ_CFG_OFS, 8'h14);
    wr(ssadc_pkg::MODE_CFG_OFS, 8'h11);
    wr(ssadc_pkg::MASK_OFS, 8'h03);
    rd(ssadc_pkg::MASK_OFS, 8'h03);
    wr(ssadc_pkg::START_OFS, 8'h01);
    slot(3'h0);
    // look at once, the next start pulse is already out
    idle_chk(0, 1'b1);
    chk({19'h0_0000, irq}, 20'h0_0000);
    slot(3'h1);
    slot(3'h2);
    idle_chk(4, 1'b0);
    chk({19'h0_0000, irq}, 20'h0_0001);
    rd(ssadc_pkg::STATUS_OFS, 8'h02);
    wr(ssadc_pkg::STATUS_OFS, 8'h03);
    $display("test sequence done");
    // continuous channel 1 runs until start is cleared
    wr(ssadc_pkg::START_OFS, 8'h00);
    wr(ssadc_pkg::SEQ_CFG_OFS, 8'h0a);
    wr(ssadc_pkg::START_OFS, 8'h01);
    for (int i = 0; i < 3; i++)
      slot(3'h1);
    idle_chk(1, 1'b1);
    wr(ssadc_pkg::START_OFS, 8'h00);
    idle_chk(3, 1'b0);
    $display("test continuous done");
    end_sim();
  end
endmodule : ssadc_seq_tb_top
